/* design/sfport_consts.vh */
`ifndef SFPORT_CONSTS_VH
`define SFPORT_CONSTS_VH
// Array geometry
`define SF_ADDR_W 19
`define SF_SECT_W 3
`define SF_PAGE_W 8
`define SF_BYTE_W 8
`define SF_PAGE_BYTES 9'h100
// Command codes: local encoding of the port's command decoder
`define CMD_WREN 8'h06
`define CMD_WRDI 8'h04
`define CMD_RDSR 8'h05
`define CMD_WRSR 8'h01
`define CMD_READ 8'h03
`define CMD_PP 8'h02
`define CMD_SE 8'hD8
`define CMD_BE 8'hC7
// Status bit positions
`define ST_BUSY 0
`define ST_WEL 1
`define ST_GUARD_LSB 2
`define ST_GUARD_MSB 4
// Internal cycle length in clocks
`define BUSY_CYCLES 16'h0040
`endif

/* design/sf_spi_port.v */
// How it works
// - Output bit changes after each clock fall
// - Input line sampled on clock rise
// - Command, address, data all from input line
// - Deselected means output released, high impedance
// - Standby when deselected unless cycle runs
// - Select low enables and makes active
// - No command before first select fall
// - Pause freezes sequence, keeps selection
// - Paused: output released, clock and input ignored
// - Pause honoured only while selected
// - Write protect freezes area guard bits
// - Modes 0 and 3 both supported
// - Eight sectors, 256 pages, 256 bytes
// - Page program takes 1 to 256 bytes
// - Bulk erase or single sector erase
// - Pause changes only while clock low, except the clear on deselect
// - Status write and erases need clock count multiple of eight
`timescale 1ns/1ns
`include "sfport_consts.vh"
module sf_spi_port #(
	parameter BUSY_LEN = `BUSY_CYCLES
) (
	input wire ref_clk_i,
	input wire rstn_i,
	input wire sclk_i,
	input wire sel_n_i,
	input wire mosi_i,
	input wire pause_n_i,
	input wire wprot_n_i,
	output reg miso_o,
	output reg miso_oe_n_o,
	output reg active_o,
	output reg busy_o,
	output reg [2:0] area_guard_o,
	output reg [`SF_ADDR_W-1:0] op_addr_o,
	output reg wr_stb_o,
	output reg [7:0] wr_data_o,
	output reg erase_stb_o,
	output reg erase_all_o,
	input wire [7:0] rd_data_i
);
	// Three-stage synchronisers; stage one feeds only stage two
	// Every pin arrives from the master's timing domain; all but the data input,
	// which is taken from stage three alone, count once stages two and three agree.
	// The cost is about four reference clocks of lag on each pin, which
	// bounds the serial clock to well below a quarter of the local clock.
	reg [2:0] ck_s, cs_s, di_s, ho_s, wp_s;
	reg ck_q, cs_q, ho_q, wp_q; // Agreed, debounced levels
	// Command state
	// The engine below keeps one frame's worth of context: where it is in
	// the current byte, how many bytes have passed, the command byte and
	// the address being built. A select fall clears the bit and byte counts, not the command or address.
	reg armed_q; // First select fall seen
	reg paused_q; // Pause in force, sequence frozen
	reg [2:0] bit_q; // Bit position in byte
	reg [8:0] byte_q; // Byte count in frame, saturates
	reg [7:0] sh_q; // Input shift
	reg [7:0] cmd_q;
	reg [7:0] out_q; // Output shift
	reg [`SF_ADDR_W-1:0] addr_q;
	reg [8:0] pp_cnt_q; // Bytes queued this page program
	reg wel_q;
	reg [2:0] guard_q;
	reg [2:0] sr_new_q;
	// Internal cycle countdown; nonzero means a write cycle is running.
	// Everything that gates new write commands looks at this one counter.
	reg [15:0] busy_q;
	reg pend_q; // Write cycle awaiting frame end check
	reg [1:0] pend_kind_q; // 0 status, 1 page, 2 sector, 3 bulk
	reg drive_q;
	wire ck_rise = ck_s[2] & ~ck_q & ck_s[1];
	wire ck_fall = ~ck_s[2] & ck_q & ~ck_s[1];
	wire cs_lvl = (cs_s[2] == cs_s[1]) ? cs_s[2] : cs_q;
	wire ho_lvl = (ho_s[2] == ho_s[1]) ? ho_s[2] : ho_q;
	wire [7:0] nbyte = {sh_q[6:0], di_s[2]};
	// Live only while armed, selected and not paused; every serial action
	// is qualified by this single term, so a pause freezes bit and byte
	// counters exactly where they stood
	wire live = armed_q & ~cs_q & ~paused_q;
	// True when a sector lies in the guarded area
	// Codes one to three guard the top one, two or four sectors; any code
	// with the top bit set guards the whole array. Zero guards nothing.
	// Shared by sector erase and page program, hence a function.
	function prot;
		input [2:0] g;
		input [2:0] s;
		begin
			if (g == 3'h0)
				prot = 1'b0;
			else if (g[2])
				prot = 1'b1;
			else
				prot = (s >= (3'h7 - ((3'h1 << (g[1:0] - 2'h1)) - 3'h1)));
		end
	endfunction
	// Synchronise every pin; levels other than the data input counted once stages two and three agree
	// Reset parks select, pause and protect at their released levels so
	// that no false select fall or pause edge follows the reset release.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ck_s <= 3'h0;
			cs_s <= 3'h7;
			di_s <= 3'h0;
			ho_s <= 3'h7;
			wp_s <= 3'h7;
			ck_q <= 1'b0;
			cs_q <= 1'b1;
			ho_q <= 1'b1;
			wp_q <= 1'b1;
		end else begin
			ck_s <= {ck_s[1:0], sclk_i};
			cs_s <= {cs_s[1:0], sel_n_i};
			di_s <= {di_s[1:0], mosi_i};
			ho_s <= {ho_s[1:0], pause_n_i};
			wp_s <= {wp_s[1:0], wprot_n_i};
			if (ck_s[2] == ck_s[1])
				ck_q <= ck_s[2]; // Either idle level is fine
			cs_q <= cs_lvl;
			ho_q <= ho_lvl;
			if (wp_s[2] == wp_s[1])
				wp_q <= wp_s[2];
		end
	end
	// Protocol engine
	// One process holds the whole serial engine. Its order matters: the
	// frame start and frame end handling come first, the sampling on the
	// clock rise later, so a command bit taken in the same cycle as a
	// frame event wins over the frame bookkeeping.
	// Strobes towards the array are single-cycle pulses cleared on entry.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			armed_q <= 1'b0;
			paused_q <= 1'b0;
			bit_q <= 3'h0;
			byte_q <= 9'h000;
			sh_q <= 8'h00;
			cmd_q <= 8'h00;
			out_q <= 8'h00;
			addr_q <= {`SF_ADDR_W{1'b0}};
			pp_cnt_q <= 9'h000;
			wel_q <= 1'b0;
			guard_q <= 3'h0;
			sr_new_q <= 3'h0;
			busy_q <= 16'h0000;
			pend_q <= 1'b0;
			pend_kind_q <= 2'h0;
			drive_q <= 1'b0;
			miso_o <= 1'b0;
			miso_oe_n_o <= 1'b1;
			active_o <= 1'b0;
			busy_o <= 1'b0;
			area_guard_o <= 3'h0;
			op_addr_o <= {`SF_ADDR_W{1'b0}};
			wr_stb_o <= 1'b0;
			wr_data_o <= 8'h00;
			erase_stb_o <= 1'b0;
			erase_all_o <= 1'b0;
		end else begin
			wr_stb_o <= 1'b0;
			erase_stb_o <= 1'b0;
			if (busy_q != 16'h0000)
				busy_q <= busy_q - 16'h0001;
			// Select fall arms the port and restarts the frame
			if (cs_q & ~cs_lvl) begin
				armed_q <= 1'b1;
				bit_q <= 3'h0;
				byte_q <= 9'h000;
				pp_cnt_q <= 9'h000;
				pend_q <= 1'b0;
				drive_q <= 1'b0;
			end
			// Pause only set or lifted with clock low while selected; deselect clears it at once
			// A pause edge seen with the clock high waits here until the
			// clock falls, so the bit in flight is never split
			if (~cs_q & ~ck_q)
				paused_q <= ~ho_q; // Position kept, nothing reset
			if (cs_q)
				paused_q <= 1'b0;
			// Frame end: commit writes only on whole bytes
			// A partial last byte leaves bit_q nonzero and the pending
			// write is dropped; the latch is cleared in that case too.
			if (~cs_q & cs_lvl) begin
				drive_q <= 1'b0;
				if (pend_q && bit_q == 3'h0) begin
					busy_q <= BUSY_LEN[15:0];
					wel_q <= 1'b0;
					case (pend_kind_q)
						2'h0: begin
							// Protect pin checked again at commit as well
							if (wp_q)
								guard_q <= sr_new_q;
						end
						2'h2: begin
							erase_stb_o <= 1'b1; // One sector erase
							erase_all_o <= 1'b0;
							op_addr_o <= {addr_q[`SF_ADDR_W-1:16], 16'h0000};
						end
						2'h3: begin
							erase_stb_o <= 1'b1; // Whole array erase
							erase_all_o <= 1'b1;
							op_addr_o <= {`SF_ADDR_W{1'b0}};
						end
						default: begin
							// Page program: bytes already strobed, only the cycle runs
							busy_q <= BUSY_LEN[15:0];
						end
					endcase
				end
				pend_q <= 1'b0;
			end
			// Sample input on clock rise, ignored when paused
			if (live & ck_rise) begin
				sh_q <= nbyte;
				bit_q <= bit_q + 3'h1;
				if (bit_q == 3'h7) begin
					if (byte_q != 9'h1FF)
						byte_q <= byte_q + 9'h001;
					if (byte_q == 9'h000) begin
						cmd_q <= nbyte;
						if (nbyte == `CMD_WREN && busy_q == 16'h0000)
							wel_q <= 1'b1;
						if (nbyte == `CMD_WRDI && busy_q == 16'h0000)
							wel_q <= 1'b0;
						if (nbyte == `CMD_RDSR) begin
							out_q <= {3'h0, guard_q, wel_q, (busy_q != 16'h0000)};
							drive_q <= 1'b1;
						end
						if (nbyte == `CMD_BE && wel_q && busy_q == 16'h0000 &&
							guard_q == 3'h0) begin
							pend_q <= 1'b1;
							pend_kind_q <= 2'h3;
						end
					end else if (cmd_q == `CMD_WRSR && byte_q == 9'h001) begin
						// Guard bits frozen while protect pin low
						if (wel_q && busy_q == 16'h0000 && wp_q) begin
							sr_new_q <= nbyte[`ST_GUARD_MSB:`ST_GUARD_LSB];
							pend_q <= 1'b1;
							pend_kind_q <= 2'h0;
						end
					end else if (byte_q <= 9'h003) begin
						// Byte address decode: sector, page, byte
						addr_q <= {addr_q[10:0], nbyte};
						if (byte_q == 9'h003) begin
							if (cmd_q == `CMD_READ) begin
								op_addr_o <= {addr_q[10:0], nbyte};
								drive_q <= 1'b1;
							end
							if (cmd_q == `CMD_SE && wel_q && busy_q == 16'h0000 &&
								!prot(guard_q, addr_q[10:8])) begin
								pend_q <= 1'b1;
								pend_kind_q <= 2'h2;
							end
						end
					end else if (cmd_q == `CMD_PP && wel_q && busy_q == 16'h0000 &&
						!prot(guard_q, addr_q[`SF_ADDR_W-1:16])) begin
						// Up to one page, wrapping in page
						if (pp_cnt_q != `SF_PAGE_BYTES) begin
							pp_cnt_q <= pp_cnt_q + 9'h001;
							wr_stb_o <= 1'b1;
							wr_data_o <= nbyte;
							op_addr_o <= addr_q;
							addr_q[7:0] <= addr_q[7:0] + 8'h01;
							pend_q <= 1'b1;
							pend_kind_q <= 2'h1;
						end
					end
				end
			end
			// Shift output on clock fall
			// A read fetches the next byte from the array at each byte
			// boundary and steps the address linearly; the status read
			// sends its byte once, then zeros, as its shift fills with zeros.
			// Limitation: the array must answer within one local clock.
			if (live & ck_fall & drive_q) begin
				if (bit_q == 3'h0 && cmd_q == `CMD_READ && byte_q > 9'h003) begin
					miso_o <= rd_data_i[7];
					out_q <= {rd_data_i[6:0], 1'b0};
					op_addr_o <= op_addr_o + {{(`SF_ADDR_W-1){1'b0}}, 1'b1};
				end else if (bit_q == 3'h0 && cmd_q == `CMD_RDSR) begin
					miso_o <= out_q[7];
					out_q <= {out_q[6:0], out_q[7]};
				end else begin
					miso_o <= out_q[7];
					out_q <= {out_q[6:0], 1'b0};
				end
			end
			// Output enable only in data phase, selected, unpaused
			// Released whenever deselected, paused or outside data-out
			miso_oe_n_o <= ~(live & drive_q);
			// Active while selected or a cycle runs, else standby
			active_o <= ~cs_q | (busy_q != 16'h0000);
			// Registered copies so every output leaves a flip-flop
			busy_o <= (busy_q != 16'h0000);
			area_guard_o <= guard_q; // Guard bits shown to the array side
		end
	end
endmodule // sf_spi_port

/* sim/sf_spi_port_sva.sv */
`timescale 1ns/1ns
// Pin-level checks of the serial port
module sf_spi_port_sva (
	input wire ref_clk_i,
	input wire rstn_i,
	input wire sclk_i,
	input wire sel_n_i,
	input wire pause_n_i,
	input wire wprot_n_i,
	input wire miso_o,
	input wire miso_oe_n_o,
	input wire active_o,
	input wire busy_o,
	input wire [2:0] area_guard_o,
	input wire wr_stb_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	a_desel_quiet: assert property (sel_n_i[*8] |-> miso_oe_n_o)
		else $error("driven while deselected");
	a_pause_quiet: assert property ((!pause_n_i && !sel_n_i && !sclk_i)[*8] |-> miso_oe_n_o)
		else $error("driven while paused");
	a_sel_active: assert property (!sel_n_i[*8] |-> active_o)
		else $error("selected, not active");
	a_busy_active: assert property (busy_o |-> active_o)
		else $error("busy, not active");
	a_idle_standby: assert property ((sel_n_i && !busy_o)[*8] |-> !active_o)
		else $error("no standby");
	a_stb_pulse: assert property (wr_stb_o |=> !wr_stb_o)
		else $error("strobe too long");
	a_stb_framed: assert property (wr_stb_o |-> !sel_n_i)
		else $error("strobe outside frame");
	a_out_on_fall: assert property (!miso_oe_n_o && !$past(miso_oe_n_o) && $changed(miso_o)
		|-> !$past(sclk_i, 2)) else $error("output moved off a fall");
	a_guard_frozen: assert property (!wprot_n_i && !$past(wprot_n_i) |-> $stable(area_guard_o))
		else $error("guard changed");
endmodule // sf_spi_port_sva
bind sf_spi_port sf_spi_port_sva sf_spi_port_sva_i (.ref_clk_i, .rstn_i, .sclk_i, .sel_n_i,
	.pause_n_i, .wprot_n_i, .miso_o, .miso_oe_n_o, .active_o, .busy_o, .area_guard_o, .wr_stb_o);

/* sim/sf_master_model.sv */
`timescale 1ns/1ns
// Serial master; its clock parks at the idle level between frames
module sf_master_model (
	input wire clk_i,
	input wire miso_i,
	output reg sclk_o,
	output reg sel_n_o,
	output reg mosi_o,
	output reg pause_n_o
);
	reg cpol; // Idle level: 0 in mode 0, 1 in mode 3
	integer pz; // Byte countdown to a pause
	initial begin
		{cpol, sclk_o, sel_n_o, mosi_o, pause_n_o} = 5'h05;
		pz = -1;
	end
	// Select fall opens every frame
	task start;
		sclk_o <= cpol;
		repeat (10) @(posedge clk_i);
		sel_n_o <= 1'b0;
		repeat (10) @(posedge clk_i);
	endtask
	task stop;
		sclk_o <= cpol;
		repeat (10) @(posedge clk_i);
		sel_n_o <= 1'b1;
		mosi_o <= ~mosi_o; // Stale bit never lingers
		@(posedge clk_i);
	endtask
	// Drive together with the fall, read just before the rise
	task bits(input [7:0] tx, input integer n, output [7:0] rx);
		integer i;
		rx = 8'h00;
		pz = pz - 1;
		for (i = n - 1; i >= 0; i = i - 1) begin
			sclk_o <= 1'b0;
			if (pz == 0 && i == 3) begin
				repeat (10) @(posedge clk_i);
				pause_n_o <= 1'b0; // Only with clock low
				repeat (10) @(posedge clk_i);
				sclk_o <= 1'b1; // Wiggle that must be ignored
				mosi_o <= ~tx[i];
				repeat (10) @(posedge clk_i);
				sclk_o <= 1'b0;
				repeat (10) @(posedge clk_i);
				pause_n_o <= 1'b1;
			end
			mosi_o <= tx[i];
			repeat (10) @(posedge clk_i);
			rx[i] = miso_i;
			sclk_o <= 1'b1;
			repeat (10) @(posedge clk_i);
		end
	endtask
endmodule // sf_master_model

/* sim/tb_sf_spi_port.sv */
`timescale 1ns/1ns
`include "sfport_consts.vh"
`define CHK(a, b) begin n_compared = n_compared + 1; if ((a) !== (b)) begin \
	failures = failures + 1; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_sf_spi_port;
	reg clk, rstn, wprot_n, tog;
	reg [7:0] rs; // Status byte read back
	integer failures, n_compared, seed, cyc, j;
	reg [7:0] mem [0:524287]; // Array behind the port
	reg [7:0] ref_m [0:524287]; // Expected contents
	wire sclk, sel_n, mosi, pause_n, miso, oe_n, sdo, active, busy, wr_stb, er_stb, er_all;
	wire [2:0] guard;
	wire [18:0] addr;
	wire [7:0] wr_data;
	assign sdo = oe_n ? tog : miso; // Released line keeps changing
	sf_spi_port #(.BUSY_LEN(16)) sf_spi_port_i (.ref_clk_i(clk), .rstn_i(rstn), .sclk_i(sclk),
		.sel_n_i(sel_n), .mosi_i(mosi), .pause_n_i(pause_n), .wprot_n_i(wprot_n), .miso_o(miso),
		.miso_oe_n_o(oe_n), .active_o(active), .busy_o(busy), .area_guard_o(guard),
		.op_addr_o(addr), .wr_stb_o(wr_stb), .wr_data_o(wr_data), .erase_stb_o(er_stb),
		.erase_all_o(er_all), .rd_data_i(mem[addr]));
	sf_master_model m_i (.clk_i(clk), .miso_i(sdo), .sclk_o(sclk), .sel_n_o(sel_n),
		.mosi_o(mosi), .pause_n_o(pause_n));
	initial begin
		{clk, rstn, wprot_n, tog} = 4'h0; // Protect pin always driven
		{failures, n_compared, cyc, seed} = {32'd0, 32'd0, 32'd0, 32'd12458};
		for (j = 0; j < 524288; j = j + 1) {mem[j], ref_m[j]} = 16'hFFFF;
		forever #4 clk = ~clk;
	end
	// Array side: program clears bits, erase sets a sector or all
	always @(posedge clk) begin
		tog <= ~tog;
		cyc = cyc + 1;
		if (wr_stb) mem[addr] = mem[addr] & wr_data;
		if (er_stb) for (j = 0; j < 524288; j = j + 1)
			if (er_all || j[18:16] == addr[18:16]) mem[j] = 8'hFF;
		if (cyc == 40000) begin
			failures = failures + 1;
			results;
		end
	end
	task results;
		if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task frame(input [7:0] c, input [23:0] a, input integer na, nd, xb);
		integer k;
		reg [7:0] d, r;
		m_i.start;
		m_i.bits(c, 8, r);
		for (k = na - 1; k >= 0; k = k - 1) m_i.bits(a[k*8 +: 8], 8, r);
		for (k = 0; k < nd; k = k + 1) begin
			d = $random(seed);
			m_i.bits(d, 8, r);
			if (c == `CMD_PP) ref_m[{a[18:8], a[7:0] + k[7:0]}] = ref_m[{a[18:8], a[7:0] + k[7:0]}] & d;
			else `CHK(r, ref_m[a[18:0] + k])
		end
		if (xb > 0) m_i.bits(8'h00, xb, d);
		m_i.stop;
	endtask
	// Write-type frame, then expect the internal cycle to run or not
	task wr(input [7:0] c, input [23:0] a, input integer na, nd, xb, input e);
		integer k;
		frame(`CMD_WREN, 0, 0, 0, 0);
		frame(c, a, na, nd, xb);
		repeat (6) @(negedge clk);
		`CHK(busy, e)
		`CHK(active, e)
		for (k = 0; k < 200 && busy !== 1'b0; k = k + 1) @(negedge clk);
		repeat (2) @(negedge clk);
		`CHK(active, 1'b0)
		@(posedge clk);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		wr(`CMD_WRSR, 24'h0C, 1, 0, 0, 0);
		`CHK(guard, 3'h0)
		wprot_n <= 1'b1;
		wr(`CMD_WRSR, 24'h04, 1, 0, 0, 1);
		`CHK(guard, 3'h1)
		wr(`CMD_SE, 24'h070000, 3, 0, 0, 0);
		wr(`CMD_PP, 24'h0120FE, 3, 3, 0, 1);
		m_i.cpol = 1'b1;
		frame(`CMD_READ, 24'h0120FE, 3, 3, 0);
		m_i.cpol = 1'b0;
		m_i.pz = 5;
		frame(`CMD_READ, 24'h012000, 3, 2, 0);
		wr(`CMD_SE, 24'h010000, 3, 0, 3, 0);
		wr(`CMD_SE, 24'h010000, 3, 0, 0, 1);
		for (j = 0; j < 65536; j = j + 1) ref_m[{3'h1, j[15:0]}] = 8'hFF;
		frame(`CMD_READ, 24'h0120FE, 3, 3, 0);
		m_i.start;
		m_i.bits(`CMD_RDSR, 8, rs);
		m_i.bits(8'h00, 8, rs);
		`CHK(rs, 8'h04)
		m_i.stop;
		results;
	end
endmodule // tb_sf_spi_port
